// [shared/dim_pkg.sv]
// Purpose: Constants and types of the digital input function mapper
// Assumes: 32-bit register port, word-aligned offsets
// Notes:   Function codes 0 to 20; codes 4, 5, 8 to 11, 18 and 19 for base inputs only
package dim_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_BASE = 3;
  localparam int NUM_ACC = 36;
  localparam int NUM_IN = NUM_BASE + NUM_ACC;
  localparam int FUNC_W = 5;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NUM_RES = 6;
  localparam int ST_W = 4;

  // ----------------------------------------
  // Input positions
  // ----------------------------------------
  localparam int IDX_BASE_ONE = 0;
  localparam int IDX_BASE_TWO = 1;
  localparam int IDX_THIRD_BASE = 2;

  // ----------------------------------------
  // Function codes
  // ----------------------------------------
  localparam logic [FUNC_W-1:0] FN_NONE = 5'h00;
  localparam logic [FUNC_W-1:0] FN_ENABLE = 5'h01;
  localparam logic [FUNC_W-1:0] FN_STOP_HI = 5'h02;
  localparam logic [FUNC_W-1:0] FN_STOP_LO = 5'h03;
  localparam logic [FUNC_W-1:0] FN_FAST_CNT = 5'h04;
  localparam logic [FUNC_W-1:0] FN_CNT_RESET = 5'h05;
  localparam logic [FUNC_W-1:0] FN_CLEAN_FAULT = 5'h06;
  localparam logic [FUNC_W-1:0] FN_DIRECTION = 5'h07;
  localparam logic [FUNC_W-1:0] FN_POS_RISE = 5'h08;
  localparam logic [FUNC_W-1:0] FN_POS_FALL = 5'h09;
  localparam logic [FUNC_W-1:0] FN_CNT_RISE = 5'h0A;
  localparam logic [FUNC_W-1:0] FN_CNT_FALL = 5'h0B;
  localparam logic [FUNC_W-1:0] FN_CW_HI = 5'h0C;
  localparam logic [FUNC_W-1:0] FN_CW_LO = 5'h0D;
  localparam logic [FUNC_W-1:0] FN_CCW_HI = 5'h0E;
  localparam logic [FUNC_W-1:0] FN_CCW_LO = 5'h0F;
  localparam logic [FUNC_W-1:0] FN_BOTH_RISE = 5'h12;
  localparam logic [FUNC_W-1:0] FN_BOTH_FALL = 5'h13;
  localparam logic [FUNC_W-1:0] FN_EXT_FAULT = 5'h14;
  localparam logic [FUNC_W-1:0] FN_MAX = 5'h14;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFS_SEL_BASE = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h100;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h104;
  localparam logic [ADDR_W-1:0] OFS_MASK = 12'h108;
  localparam logic [ADDR_W-1:0] OFS_LEVEL_LO = 12'h10C;
  localparam logic [ADDR_W-1:0] OFS_LEVEL_HI = 12'h110;
  localparam logic [ADDR_W-1:0] OFS_RESULT_BASE = 12'h120;

  // ----------------------------------------
  // Capture result slots, status bits and the control register bit
  // ----------------------------------------
  localparam int RES_POS_RISE = 0;
  localparam int RES_POS_FALL = 1;
  localparam int RES_CNT_RISE = 2;
  localparam int RES_CNT_FALL = 3;
  localparam int RES_BOTH_POS = 4;
  localparam int RES_BOTH_CNT = 5;
  localparam int ST_CAPTURE = 0;
  localparam int ST_LIMIT = 1;
  localparam int ST_FAULT = 2;
  localparam int ST_REFUSED = 3;
  localparam int CTRL_TORQUE = 0;

  typedef enum logic [2:0] {GRP_NONE, GRP_ENABLE, GRP_STOP, GRP_CW, GRP_CCW} dim_grp_t;

endpackage : dim_pkg

// [shared/dim_sync_if.sv]
// Purpose: Synchronised input levels and edge pulses
// Assumes: One clock domain
// Notes:   Edges are single-cycle pulses
`timescale 1ns/10ps
`default_nettype none
interface dim_sync_if #(parameter int N = 39);
  logic [N-1:0] level;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : dim_sync_if
`default_nettype wire

// [core/dim_input_sync.sv]
// Purpose: Two-stage synchroniser and edge detect per digital input
// Assumes: High input level means contact closed
// Notes:   Edges appear two clocks after the pin changes
`timescale 1ns/10ps
`default_nettype none
module dim_input_sync import dim_pkg::*; #(
  parameter int N = NUM_IN
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [N-1:0] raw_in,
  dim_sync_if.src sync
);

  typedef struct packed {
    logic [N-1:0] meta;
    logic [N-1:0] stab;
    logic [N-1:0] prev;
  } dim_sync_state_t;

  dim_sync_state_t r;
  dim_sync_state_t next_r;

  // ----------------------------------------
  // Synchroniser chain
  // ----------------------------------------
  always_comb begin
    next_r = r;
    next_r.meta = raw_in;
    next_r.stab = r.meta;
    next_r.prev = r.stab;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Edges from stable stages only, never from the metastable one
  assign sync.level = r.stab;
  assign sync.rise = r.stab & ~r.prev;
  assign sync.fall = ~r.stab & r.prev;

  a_single_rise:
  assert property (@(posedge sys_clk) disable iff (!resetn) sync.rise[0] |=> !sync.rise[0])
    else $error("rise pulse longer than one cycle");

endmodule : dim_input_sync
`default_nettype wire

// [core/dim_mapper.sv]
// Purpose: Maps each digital input to a selectable drive function
// Assumes: Inputs synchronous-free pins; high level = contact closed
// Notes:   Selectors, control, status, mask and results on a word port
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module dim_mapper import dim_pkg::*; #(
  parameter int POS_W = 32,
  parameter int CNT_W = 32
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [NUM_IN-1:0] din,
  input wire logic [POS_W-1:0] motor_position,
  input wire logic [CNT_W-1:0] pulse_counter,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rdata,
  output logic irq,
  output logic limit_cw_active,
  output logic limit_ccw_active,
  output logic current_ref_zero,
  output logic ext_fault,
  output logic drive_enable,
  output logic stop_shaft,
  output logic fast_count_pulse,
  output logic fast_count_reset,
  output logic fault_clear,
  output logic dir_invert
);

  typedef struct packed {
    logic [NUM_IN-1:0][FUNC_W-1:0] sel;
    logic [NUM_RES-1:0][DATA_W-1:0] res;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic torque;
    logic [DATA_W-1:0] rdata;
    logic irq;
    logic cw;
    logic ccw;
    logic ref_zero;
    logic fault;
    logic enable;
    logic stop;
    logic fast_pulse;
    logic fast_reset;
    logic fclear;
    logic dir;
  } dim_state_t;

  dim_state_t r;
  dim_state_t next_r;
  logic refuse;
  logic sel_wr;

  dim_sync_if #(.N(NUM_IN)) sync_bus ();

  dim_input_sync #(.N(NUM_IN)) u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .raw_in(din),
    .sync(sync_bus)
  );

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic is_sel(input logic [ADDR_W-1:0] a);
    is_sel = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] < 10'(NUM_IN));
  endfunction : is_sel

  function automatic logic [ADDR_W-3:0] word_idx(input logic [ADDR_W-1:0] a);
    word_idx = a[ADDR_W-1:2];
  endfunction : word_idx

  function automatic dim_grp_t fgroup(input logic [FUNC_W-1:0] c);
    case (c)
      FN_ENABLE: fgroup = GRP_ENABLE;
      FN_STOP_HI, FN_STOP_LO: fgroup = GRP_STOP;
      FN_CW_HI, FN_CW_LO: fgroup = GRP_CW;
      FN_CCW_HI, FN_CCW_LO: fgroup = GRP_CCW;
      default: fgroup = GRP_NONE;
    endcase
  endfunction : fgroup

  // Input-specific codes are refused at write time on other inputs, so the map never holds them there
  function automatic logic code_ok(input int idx, input logic [FUNC_W-1:0] c);
    case (c)
      FN_FAST_CNT: code_ok = (idx == IDX_BASE_ONE) || (idx == IDX_BASE_TWO);
      FN_POS_RISE, FN_POS_FALL: code_ok = (idx <= IDX_THIRD_BASE);
      FN_CNT_RISE, FN_CNT_FALL: code_ok = (idx == IDX_THIRD_BASE);
      FN_BOTH_RISE, FN_BOTH_FALL: code_ok = (idx == IDX_THIRD_BASE);
      FN_CNT_RESET: code_ok = (idx == IDX_THIRD_BASE);
      default: code_ok = (c <= FN_MAX);
    endcase
  endfunction : code_ok

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    logic [FUNC_W-1:0] code;
    logic lvl;
    logic rise;
    logic fall;
    logic cw_raw;
    logic ccw_raw;
    logic cap;
    logic [ST_W-1:0] ev;
    logic [ST_W-1:0] clr;
    logic [ADDR_W-3:0] widx;
    code = FN_NONE;
    lvl = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    cw_raw = 1'b0;
    ccw_raw = 1'b0;
    cap = 1'b0;
    ev = '0;
    clr = '0;
    widx = word_idx(addr);
    refuse = 1'b0;
    sel_wr = wr_en && is_sel(addr);
    next_r = r;
    next_r.rdata = '0;
    next_r.enable = 1'b0;
    next_r.stop = 1'b0;
    next_r.fault = 1'b0;
    next_r.fast_pulse = 1'b0;
    next_r.fast_reset = 1'b0;
    next_r.fclear = 1'b0;
    next_r.dir = 1'b0;

    // Per-input function evaluation
    for (int i = 0; i < NUM_IN; i++) begin
      code = r.sel[i];
      lvl = sync_bus.level[i];
      rise = sync_bus.rise[i];
      fall = sync_bus.fall[i];
      case (code)
        FN_ENABLE: next_r.enable = next_r.enable | lvl;
        FN_STOP_HI: next_r.stop = next_r.stop | lvl;
        FN_STOP_LO: next_r.stop = next_r.stop | ~lvl;
        FN_FAST_CNT: next_r.fast_pulse = next_r.fast_pulse | rise;
        FN_CNT_RESET: next_r.fast_reset = next_r.fast_reset | lvl;
        FN_CLEAN_FAULT: next_r.fclear = next_r.fclear | rise;
        FN_DIRECTION: next_r.dir = 1'b1;
        FN_CW_HI: cw_raw = cw_raw | lvl;
        FN_CW_LO: cw_raw = cw_raw | ~lvl;
        FN_CCW_HI: ccw_raw = ccw_raw | lvl;
        FN_CCW_LO: ccw_raw = ccw_raw | ~lvl;
        FN_EXT_FAULT: next_r.fault = next_r.fault | ~lvl;
        FN_POS_RISE: begin
          if (rise) begin
            next_r.res[RES_POS_RISE] = DATA_W'(motor_position);
            cap = 1'b1;
          end
        end
        FN_POS_FALL: begin
          if (fall) begin
            next_r.res[RES_POS_FALL] = DATA_W'(motor_position);
            cap = 1'b1;
          end
        end
        FN_CNT_RISE: begin
          if (rise) begin
            next_r.res[RES_CNT_RISE] = DATA_W'(pulse_counter);
            cap = 1'b1;
          end
        end
        FN_CNT_FALL: begin
          if (fall) begin
            next_r.res[RES_CNT_FALL] = DATA_W'(pulse_counter);
            cap = 1'b1;
          end
        end
        FN_BOTH_RISE, FN_BOTH_FALL: begin
          if ((code == FN_BOTH_RISE) ? rise : fall) begin
            next_r.res[RES_BOTH_POS] = DATA_W'(motor_position);
            next_r.res[RES_BOTH_CNT] = DATA_W'(pulse_counter);
            cap = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // Limits ignored in torque mode; either one zeroes the current reference
    next_r.cw = cw_raw & ~r.torque;
    next_r.ccw = ccw_raw & ~r.torque;
    next_r.ref_zero = next_r.cw | next_r.ccw;

    ev[ST_CAPTURE] = cap;
    ev[ST_LIMIT] = next_r.ref_zero & ~r.ref_zero;
    ev[ST_FAULT] = next_r.fault & ~r.fault;

    // Selector writes with duplicate-function refusal
    if (sel_wr) begin
      for (int j = 0; j < NUM_IN; j++) begin
        if ((j != int'(widx)) && (fgroup(wdata[FUNC_W-1:0]) != GRP_NONE) &&
            (fgroup(r.sel[j]) == fgroup(wdata[FUNC_W-1:0]))) begin
          refuse = 1'b1;
        end
      end
      if (wdata[DATA_W-1:FUNC_W] != '0 || !code_ok(int'(widx), wdata[FUNC_W-1:0])) begin
        refuse = 1'b1;
      end
      if (refuse) begin
        ev[ST_REFUSED] = 1'b1;
      end else begin
        next_r.sel[widx] = wdata[FUNC_W-1:0];
      end
    end

    if (wr_en && addr == OFS_CTRL) begin
      next_r.torque = wdata[CTRL_TORQUE];
    end
    if (wr_en && addr == OFS_MASK) begin
      next_r.mask = wdata[ST_W-1:0];
    end
    if (wr_en && addr == OFS_STATUS) begin
      clr = wdata[ST_W-1:0];
    end
    // A new event wins over a clear in the same cycle
    next_r.status = (r.status & ~clr) | ev;
    next_r.irq = |(next_r.status & next_r.mask);

    // ----------------------------------------
    // Read data, valid in the cycle after the strobe
    // ----------------------------------------
    if (rd_en) begin
      if (is_sel(addr)) begin
        next_r.rdata = DATA_W'(r.sel[widx]);
      end else if (addr == OFS_CTRL) begin
        next_r.rdata = DATA_W'(r.torque);
      end else if (addr == OFS_STATUS) begin
        next_r.rdata = DATA_W'(r.status);
      end else if (addr == OFS_MASK) begin
        next_r.rdata = DATA_W'(r.mask);
      end else if (addr == OFS_LEVEL_LO) begin
        next_r.rdata = sync_bus.level[DATA_W-1:0];
      end else if (addr == OFS_LEVEL_HI) begin
        next_r.rdata = DATA_W'(sync_bus.level[NUM_IN-1:DATA_W]);
      end else if (addr[1:0] == 2'h0 && addr >= OFS_RESULT_BASE &&
                   addr < OFS_RESULT_BASE + ADDR_W'(4 * NUM_RES)) begin
        next_r.rdata = r.res[3'(word_idx(addr - OFS_RESULT_BASE))];
      end else begin
        next_r.rdata = '0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata = r.rdata;
  assign irq = r.irq;
  assign limit_cw_active = r.cw;
  assign limit_ccw_active = r.ccw;
  assign current_ref_zero = r.ref_zero;
  assign ext_fault = r.fault;
  assign drive_enable = r.enable;
  assign stop_shaft = r.stop;
  assign fast_count_pulse = r.fast_pulse;
  assign fast_count_reset = r.fast_reset;
  assign fault_clear = r.fclear;
  assign dir_invert = r.dir;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_pos_rise;
    r.sel[IDX_BASE_ONE] == FN_POS_RISE && sync_bus.rise[IDX_BASE_ONE];
  endsequence
  sequence s_pos_fall;
    r.sel[IDX_BASE_TWO] == FN_POS_FALL && sync_bus.fall[IDX_BASE_TWO];
  endsequence
  sequence s_third(logic [FUNC_W-1:0] c, logic e);
    r.sel[IDX_THIRD_BASE] == c && e;
  endsequence

  a_pos_rise_capture:
  assert property (s_pos_rise |=> r.res[RES_POS_RISE] == $past(motor_position))
    else $error("position not latched on rising edge");
  a_pos_fall_capture:
  assert property (s_pos_fall |=> r.res[RES_POS_FALL] == $past(motor_position))
    else $error("position not latched on falling edge");
  a_cnt_rise_capture:
  assert property (s_third(FN_CNT_RISE, sync_bus.rise[IDX_THIRD_BASE])
                   |=> r.res[RES_CNT_RISE] == $past(pulse_counter) && r.status[ST_CAPTURE])
    else $error("counter not latched on rising edge");
  a_cnt_fall_capture:
  assert property (s_third(FN_CNT_FALL, sync_bus.fall[IDX_THIRD_BASE])
                   |=> r.res[RES_CNT_FALL] == $past(pulse_counter))
    else $error("counter not latched on falling edge");
  a_both_capture:
  assert property (s_third(FN_BOTH_FALL, sync_bus.fall[IDX_THIRD_BASE])
                   |=> r.res[RES_BOTH_POS] == $past(motor_position) && r.res[RES_BOTH_CNT] == $past(pulse_counter))
    else $error("combined capture missed");
  a_cw_open_active:
  assert property (r.sel[IDX_BASE_ONE] == FN_CW_LO && !sync_bus.level[IDX_BASE_ONE] && !r.torque |=> limit_cw_active)
    else $error("low-active clockwise limit not asserted");
  a_ccw_closed_active:
  assert property (r.sel[IDX_BASE_TWO] == FN_CCW_HI && sync_bus.level[IDX_BASE_TWO] && !r.torque |=> limit_ccw_active)
    else $error("high-active counterclockwise limit not asserted");
  a_limit_zero_ref:
  assert property (r.sel[IDX_BASE_ONE] == FN_CW_HI && sync_bus.level[IDX_BASE_ONE] && !r.torque |=> current_ref_zero)
    else $error("current reference not tied to limits");
  a_torque_ignore:
  assert property (r.torque && $stable(r.torque) |-> !limit_cw_active && !limit_ccw_active)
    else $error("limit active in torque mode");
  a_ext_fault_open:
  assert property (r.sel[IDX_BASE_ONE] == FN_EXT_FAULT && !sync_bus.level[IDX_BASE_ONE] |=> ext_fault)
    else $error("external fault not raised");
  a_refuse_keeps:
  assert property (sel_wr && refuse |=> $stable(r.sel) ##0 r.status[ST_REFUSED])
    else $error("refused selector write took effect");
  a_fast_count:
  assert property (r.sel[IDX_BASE_TWO] == FN_FAST_CNT && sync_bus.rise[IDX_BASE_TWO] |=> fast_count_pulse)
    else $error("fast counter pulse missing");

endmodule : dim_mapper
`default_nettype wire

// [verif/dim_contact_model.sv]
// Purpose: Switches and sensors wired to the digital inputs
// Assumes: High level means contact closed; contacts do not bounce
// Notes:   All contacts start open
`timescale 1ns/10ps
`default_nettype none
module dim_contact_model import dim_pkg::*; (
  input wire logic sys_clk,
  output logic [NUM_IN-1:0] din
);
  initial din = '0;

  // ----------------------------------------
  // Contact control
  // ----------------------------------------
  // Moves just after an edge so the pin never changes on the sampling edge
  task automatic set_contact(input int idx, input logic closed);
    @(posedge sys_clk);
    din[idx] <= closed;
  endtask : set_contact
endmodule : dim_contact_model
`default_nettype wire

// [verif/tb.sv]
// Purpose: Self-checking bench of the digital input function mapper
// Assumes: Level outputs settle within five clocks of a pin change
// Notes:   Every scenario except t_reset programs selectors over the word port
`timescale 1ns/10ps
`default_nettype none
module tb import dim_pkg::*; ;
  logic sys_clk, resetn, wr_en, rd_en;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [31:0] motor_position, pulse_counter;
  logic [NUM_IN-1:0] din;
  logic irq, limit_cw_active, limit_ccw_active, current_ref_zero, ext_fault;
  logic drive_enable, stop_shaft, fast_count_pulse, fast_count_reset, fault_clear, dir_invert;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n_fast = 0;
  int n_fclear = 0;

  dim_contact_model dim_contact_model_inst (.sys_clk(sys_clk), .din(din));
  dim_mapper dim_mapper_inst (.sys_clk(sys_clk), .resetn(resetn), .din(din),
    .motor_position(motor_position), .pulse_counter(pulse_counter), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq),
    .limit_cw_active(limit_cw_active), .limit_ccw_active(limit_ccw_active),
    .current_ref_zero(current_ref_zero), .ext_fault(ext_fault), .drive_enable(drive_enable),
    .stop_shaft(stop_shaft), .fast_count_pulse(fast_count_pulse),
    .fast_count_reset(fast_count_reset), .fault_clear(fault_clear), .dir_invert(dir_invert));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic final_report;
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // Run takes well under a thousand clocks
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    // Pulses stand one cycle, so they are counted at every edge
    if (fast_count_pulse) n_fast++;
    if (fault_clear) n_fclear++;
    if (cycles == 5000) begin
      n_mismatch++;
      final_report;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  function automatic logic [ADDR_W-1:0] sel(input int k);
    return OFS_SEL_BASE + ADDR_W'(4 * k);
  endfunction : sel

  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : w

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rc(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string m);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    chk(rdata, exp, m);
  endtask : rc

  task automatic pin(input int idx, input logic closed);
    dim_contact_model_inst.set_contact(idx, closed);
    w(6);
  endtask : pin

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [ADDR_W-1:0] al[7] = '{sel(0), sel(38), OFS_CTRL, OFS_STATUS, OFS_MASK, OFS_RESULT_BASE, 12'h200};
    foreach (al[i]) rc(al[i], 32'h0, "reset value");
    chk({31'h0, current_ref_zero}, 32'h0, "ref zero after reset");
  endtask : t_reset

  task automatic t_refuse;
    logic [4:0] code[4] = '{FN_CNT_RISE, FN_FAST_CNT, FN_POS_FALL, 5'h15};
    int idx[4] = '{0, 2, 3, 10};
    for (int i = 0; i < 4; i++) begin
      wr(sel(idx[i]), {27'h0, code[i]});
      rc(sel(idx[i]), 32'h0, "refused code kept");
    end
    rc(OFS_STATUS, 32'h8, "refusal flag");
    wr(OFS_STATUS, 32'hF);
    wr(sel(10), {27'h0, FN_DIRECTION});
    rc(sel(10), 32'h7, "accessory code");
    w(2);
    chk({31'h0, dir_invert}, 32'h1, "accessory function acts");
    wr(sel(10), 32'h0);
  endtask : t_refuse

  task automatic t_capture;
    wr(sel(0), {27'h0, FN_POS_RISE});
    wr(sel(1), {27'h0, FN_POS_FALL});
    wr(sel(2), {27'h0, FN_CNT_RISE});
    motor_position <= 32'h1111_0001;
    pulse_counter <= 32'h2222_0001;
    pin(0, 1'b1);
    rc(OFS_RESULT_BASE, 32'h1111_0001, "position on rise");
    motor_position <= 32'h1111_0002;
    pin(0, 1'b0);
    rc(OFS_RESULT_BASE, 32'h1111_0001, "no capture on fall");
    pin(1, 1'b1);
    rc(OFS_RESULT_BASE + 12'h4, 32'h0, "no capture on rise");
    pin(1, 1'b0);
    rc(OFS_RESULT_BASE + 12'h4, 32'h1111_0002, "position on fall");
    pin(2, 1'b1);
    rc(OFS_RESULT_BASE + 12'h8, 32'h2222_0001, "counter on rise");
    wr(sel(2), {27'h0, FN_CNT_FALL});
    pulse_counter <= 32'h2222_0002;
    pin(2, 1'b0);
    rc(OFS_RESULT_BASE + 12'hC, 32'h2222_0002, "counter on fall");
    rc(OFS_RESULT_BASE + 12'h8, 32'h2222_0001, "rise slot untouched");
    rc(OFS_STATUS, 32'h1, "capture flag");
    wr(sel(2), {27'h0, FN_BOTH_RISE});
    motor_position <= 32'h1111_0003;
    pulse_counter <= 32'h2222_0003;
    pin(2, 1'b1);
    rc(OFS_RESULT_BASE + 12'h10, 32'h1111_0003, "both rise position");
    rc(OFS_RESULT_BASE + 12'h14, 32'h2222_0003, "both rise counter");
    wr(sel(2), {27'h0, FN_BOTH_FALL});
    motor_position <= 32'h1111_0004;
    pulse_counter <= 32'h2222_0004;
    pin(2, 1'b0);
    rc(OFS_RESULT_BASE + 12'h10, 32'h1111_0004, "both fall position");
    rc(OFS_RESULT_BASE + 12'h14, 32'h2222_0004, "both fall counter");
    wr(OFS_STATUS, 32'hF);
    rc(OFS_STATUS, 32'h0, "capture flag cleared");
  endtask : t_capture

  task automatic t_limits;
    wr(OFS_MASK, 32'h2);
    pin(1, 1'b1);
    wr(sel(0), {27'h0, FN_CW_HI});
    wr(sel(1), {27'h0, FN_CCW_LO});
    wr(sel(7), {27'h0, FN_CW_LO});
    rc(sel(7), 32'h0, "second clockwise refused");
    wr(sel(7), {27'h0, FN_CCW_HI});
    rc(sel(7), 32'h0, "second counterclockwise refused");
    chk({31'h0, current_ref_zero}, 32'h0, "no limit yet");
    pin(0, 1'b1);
    chk({30'h0, limit_cw_active, current_ref_zero}, 32'h3, "cw closed active");
    pin(0, 1'b0);
    chk({30'h0, limit_cw_active, current_ref_zero}, 32'h0, "cw released");
    chk({31'h0, irq}, 32'h1, "sticky limit irq");
    wr(OFS_STATUS, 32'hF);
    w(2);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    pin(1, 1'b0);
    chk({30'h0, limit_ccw_active, current_ref_zero}, 32'h3, "ccw open active");
    wr(OFS_CTRL, 32'h1);
    w(5);
    chk({30'h0, limit_ccw_active, current_ref_zero}, 32'h0, "torque ignores limit");
    wr(OFS_CTRL, 32'h0);
    w(5);
    chk({31'h0, limit_ccw_active}, 32'h1, "limit back");
    pin(1, 1'b1);
    chk({31'h0, limit_ccw_active}, 32'h0, "ccw closed idle");
    wr(sel(0), 32'h0);
    wr(sel(0), {27'h0, FN_CW_LO});
    w(5);
    chk({31'h0, limit_cw_active}, 32'h1, "cw low active open");
    wr(sel(1), 32'h0);
    wr(sel(1), {27'h0, FN_CCW_HI});
    w(5);
    chk({31'h0, limit_ccw_active}, 32'h1, "ccw high active closed");
    wr(sel(0), 32'h0);
    wr(sel(1), 32'h0);
    w(5);
    wr(OFS_STATUS, 32'hF);
  endtask : t_limits

  task automatic t_fault;
    wr(OFS_MASK, 32'h4);
    wr(sel(0), {27'h0, FN_EXT_FAULT});
    wr(sel(38), {27'h0, FN_EXT_FAULT});
    w(5);
    chk({30'h0, ext_fault, irq}, 32'h3, "fault while open");
    rc(OFS_STATUS, 32'h4, "fault flag");
    pin(38, 1'b1);
    chk({31'h0, ext_fault}, 32'h1, "fault while other input open");
    pin(0, 1'b1);
    chk({31'h0, ext_fault}, 32'h0, "no fault closed");
  endtask : t_fault

  task automatic t_misc;
    wr(sel(1), {27'h0, FN_FAST_CNT});
    wr(sel(2), {27'h0, FN_CNT_RESET});
    wr(sel(3), {27'h0, FN_ENABLE});
    wr(sel(4), {27'h0, FN_STOP_LO});
    wr(sel(5), {27'h0, FN_CLEAN_FAULT});
    wr(sel(9), {27'h0, FN_ENABLE});
    rc(sel(9), 32'h0, "second enable refused");
    wr(sel(9), {27'h0, FN_STOP_HI});
    rc(sel(9), 32'h0, "second stop refused");
    w(2);
    chk({29'h0, drive_enable, stop_shaft, fast_count_reset}, 32'h2, "all open");
    pin(1, 1'b0);
    pin(1, 1'b1);
    pin(1, 1'b0);
    pin(1, 1'b1);
    chk(n_fast, 32'h2, "one fast pulse per rise");
    pin(5, 1'b1);
    chk(n_fclear, 32'h1, "fault clear pulse");
    pin(3, 1'b1);
    pin(4, 1'b1);
    pin(2, 1'b1);
    chk({29'h0, drive_enable, stop_shaft, fast_count_reset}, 32'h5, "all closed");
    rc(OFS_LEVEL_LO, 32'h3F, "input levels low word");
    rc(OFS_LEVEL_HI, 32'h40, "input levels high word");
  endtask : t_misc

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    addr = '0;
    wdata = '0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    motor_position = '0;
    pulse_counter = '0;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    w(1);
    t_reset;
    t_refuse;
    t_capture;
    t_limits;
    t_fault;
    t_misc;
    final_report;
  end
endmodule : tb
`default_nettype wire
